// file: hw/tpw_pkg.sv
// Constants for the 16-bit PWM timer: register offsets, field positions,
// reset values, mode and output codes, prescaler divides.
// Assumes a 32-bit AHB-Lite register bus on one clock.
package tpw_pkg;

  // Register byte offsets
  localparam logic [7:0] TPW_OFF_CTRL  = 8'h00;
  localparam logic [7:0] TPW_OFF_CMPA  = 8'h04;
  localparam logic [7:0] TPW_OFF_CMPB  = 8'h08;
  localparam logic [7:0] TPW_OFF_CAPT  = 8'h0c;
  localparam logic [7:0] TPW_OFF_COUNT = 8'h10;
  localparam logic [7:0] TPW_OFF_FLAGS = 8'h14;

  // Control field positions
  localparam int TPW_CTRL_MODE_LSB = 0;
  localparam int TPW_CTRL_COMA_LSB = 4;
  localparam int TPW_CTRL_COMB_LSB = 6;
  localparam int TPW_CTRL_CS_LSB   = 8;
  localparam int TPW_CTRL_DIR_LSB  = 11;
  localparam int TPW_CTRL_PORT_LSB = 13;
  localparam int TPW_CTRL_WIDTH    = 15;

  // Flag bit positions
  localparam int TPW_FLG_OVF  = 0;
  localparam int TPW_FLG_CMPA = 1;
  localparam int TPW_FLG_CMPB = 2;
  localparam int TPW_FLG_CAPT = 3;

  // Reset values
  localparam logic [14:0] TPW_CTRL_RST = 15'h0000;
  localparam logic [15:0] TPW_VAL_RST  = 16'h0000;
  localparam logic [3:0]  TPW_FLG_RST  = 4'h0;

  // Counter limits
  localparam logic [15:0] TPW_BOTTOM = 16'h0000;
  localparam logic [15:0] TPW_TOP8   = 16'h00ff;
  localparam logic [15:0] TPW_TOP9   = 16'h01ff;
  localparam logic [15:0] TPW_TOP10  = 16'h03ff;
  localparam logic [15:0] TPW_MAX    = 16'hffff;

  // Register-defined top mode codes
  localparam logic [3:0] TPW_MODE_PC_CAPT   = 4'ha;
  localparam logic [3:0] TPW_MODE_PC_CMPA   = 4'hb;
  localparam logic [3:0] TPW_MODE_FAST_CAPT = 4'he;
  localparam logic [3:0] TPW_MODE_FAST_CMPA = 4'hf;

  // Compare output mode codes
  localparam logic [1:0] TPW_COM_OFF    = 2'h0;
  localparam logic [1:0] TPW_COM_TOGGLE = 2'h1;

  // Prescaler: select code and last count of each divide
  localparam logic [2:0] TPW_CS_STOP  = 3'h0;
  localparam logic [9:0] TPW_LAST_1   = 10'h000;
  localparam logic [9:0] TPW_LAST_8   = 10'h007;
  localparam logic [9:0] TPW_LAST_64  = 10'h03f;
  localparam logic [9:0] TPW_LAST_256 = 10'h0ff;
  localparam logic [9:0] TPW_LAST_1K  = 10'h3ff;

endpackage

// file: hw/tpw_presc_if.sv
// Carries the clock select to the prescaler and the timer enable back.
// Assumes both ends run on hclk.
`timescale 1ns/100ps
interface tpw_presc_if;
  logic [2:0] clk_sel;
  logic       tick;
  modport ctl   (output clk_sel, input tick);
  modport presc (input clk_sel, output tick);
endinterface

// file: hw/tpw_prescaler.sv
// Prescaler: one-cycle timer enable at hclk divided by 1, 8, 64, 256, 1024.
// Assumes clk_sel comes from a register on hclk.
`timescale 1ns/100ps
module tpw_prescaler
  import tpw_pkg::*;
(
  input  wire logic hclk,
  input  wire logic hresetn,
  tpw_presc_if.presc pif
);

  logic [9:0] div_ff;
  logic [9:0] last;
  logic       run;

  assign last = (pif.clk_sel == 3'h1) ? TPW_LAST_1 :
                (pif.clk_sel == 3'h2) ? TPW_LAST_8 :
                (pif.clk_sel == 3'h3) ? TPW_LAST_64 :
                (pif.clk_sel == 3'h4) ? TPW_LAST_256 : TPW_LAST_1K;
  assign run  = (pif.clk_sel != TPW_CS_STOP) && (pif.clk_sel <= 3'h5);
  assign pif.tick = run && (div_ff >= last);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_ff <= 10'h000;
    end else if (!run || pif.tick) begin
      div_ff <= 10'h000;
    end else begin
      div_ff <= div_ff + 10'h001;
    end
  end

endmodule

// file: hw/tpw_timer16_pwm.sv
// 16-bit timer waveform generator: fast and phase-correct PWM, two channels,
// AHB-Lite register slave. Assumes a single AHB-Lite master on hclk.
`timescale 1ns/100ps

module tpw_timer16_pwm
  import tpw_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             pin_a_out,
  output logic             pin_a_oe,
  output logic             pin_b_out,
  output logic             pin_b_oe
);

  // Bus state
  logic [7:0]  addr_ff;
  logic        wr_ff;
  logic [31:0] hrdata_ff;
  logic [31:0] nxt_hrdata;

  // Registers
  logic [14:0] ctrl_ff;
  logic [15:0] capt_ff;
  logic [15:0] cnt_ff;
  logic [15:0] nxt_cnt;
  logic        up_ff;
  logic        nxt_up;
  logic [3:0]  flags_ff;
  logic [3:0]  nxt_flags;
  logic [15:0] buf_ff [2];
  logic [15:0] act_ff [2];
  logic [1:0]  wave_ff;

  // Decoded controls
  logic [3:0]  mode;
  logic [1:0]  com [2];
  logic [1:0]  pin_dir;
  logic [1:0]  port_lvl;
  logic        tick;
  logic        fixed_top;
  logic        single;
  logic        dual;
  logic        pwm;
  logic        top_cmpa;
  logic        top_capt;
  logic [15:0] top;
  logic [15:0] wr_mask;
  logic        at_top;
  logic        at_bot;
  logic        top_ev;
  logic        bot_ev;
  logic        dir_up_m;
  logic [1:0]  match;
  logic [1:0]  hit;
  logic        ovf_set;

  // Bus decode
  logic        addr_ok;
  logic        wr_ctrl;
  logic        wr_capt;
  logic        wr_flags;
  logic [1:0]  wr_cmp;
  logic [7:0]  rd_addr;

  // Timer enable; the counter moves only on it
  tpw_presc_if u_pif ();

  tpw_prescaler u_presc (
    .hclk    (hclk),
    .hresetn (hresetn),
    .pif     (u_pif)
  );

  assign u_pif.clk_sel = ctrl_ff[TPW_CTRL_CS_LSB +: 3];
  assign tick          = u_pif.tick;

  // Zero-wait slave, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_ff;

  assign addr_ok   = hsel && hready && htrans[1];
  assign rd_addr   = haddr[7:0];
  assign wr_ctrl   = wr_ff && (addr_ff == TPW_OFF_CTRL);
  assign wr_cmp[0] = wr_ff && (addr_ff == TPW_OFF_CMPA);
  assign wr_cmp[1] = wr_ff && (addr_ff == TPW_OFF_CMPB);
  assign wr_capt   = wr_ff && (addr_ff == TPW_OFF_CAPT);
  assign wr_flags  = wr_ff && (addr_ff == TPW_OFF_FLAGS);

  always_comb begin
    nxt_hrdata = 32'h0000_0000;
    unique case (rd_addr)
      TPW_OFF_CTRL:  nxt_hrdata = {17'h00000, ctrl_ff};
      TPW_OFF_CMPA:  nxt_hrdata = {16'h0000, buf_ff[0]};
      TPW_OFF_CMPB:  nxt_hrdata = {16'h0000, buf_ff[1]};
      TPW_OFF_CAPT:  nxt_hrdata = {16'h0000, capt_ff};
      TPW_OFF_COUNT: nxt_hrdata = {16'h0000, cnt_ff};
      TPW_OFF_FLAGS: nxt_hrdata = {28'h0000000, flags_ff};
      default:       nxt_hrdata = 32'h0000_0000;
    endcase
  end

  // Read data taken in the address phase: a read right behind a write
  // to the same register sees the old value
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_ff   <= 8'h00;
      wr_ff     <= 1'b0;
      hrdata_ff <= 32'h0000_0000;
    end else begin
      addr_ff <= haddr[7:0];
      wr_ff   <= addr_ok && hwrite;
      if (addr_ok && !hwrite) begin
        hrdata_ff <= nxt_hrdata;
      end
    end
  end

  // Mode decode
  assign mode      = ctrl_ff[TPW_CTRL_MODE_LSB +: 4];
  assign com[0]    = ctrl_ff[TPW_CTRL_COMA_LSB +: 2];
  assign com[1]    = ctrl_ff[TPW_CTRL_COMB_LSB +: 2];
  assign pin_dir   = ctrl_ff[TPW_CTRL_DIR_LSB +: 2];
  assign port_lvl  = ctrl_ff[TPW_CTRL_PORT_LSB +: 2];
  assign fixed_top = !mode[3] && (mode[1:0] != 2'h0);
  assign top_cmpa  = (mode == TPW_MODE_FAST_CMPA) || (mode == TPW_MODE_PC_CMPA);
  assign top_capt  = (mode == TPW_MODE_FAST_CAPT) || (mode == TPW_MODE_PC_CAPT);
  assign single    = (fixed_top && mode[2]) ||
                     (mode == TPW_MODE_FAST_CAPT) || (mode == TPW_MODE_FAST_CMPA);
  assign dual      = (fixed_top && !mode[2]) ||
                     (mode == TPW_MODE_PC_CAPT) || (mode == TPW_MODE_PC_CMPA);
  assign pwm       = single || dual;

  // Compare A as top is the active copy, so writes act at top
  // top source select
  // capture value used live, no buffer
  assign top = (mode[1:0] == 2'h1 && fixed_top) ? TPW_TOP8 :
               (mode[1:0] == 2'h2 && fixed_top) ? TPW_TOP9 :
               (mode[1:0] == 2'h3 && fixed_top) ? TPW_TOP10 :
               top_capt ? capt_ff : act_ff[0];

  assign wr_mask = fixed_top ? top : TPW_MAX;

  assign at_top = (cnt_ff == top);
  assign at_bot = (cnt_ff == TPW_BOTTOM);
  assign top_ev = tick && at_top && (single || (dual && up_ff));
  assign bot_ev = tick && dual && at_bot && !up_ff;
  // Match at bottom counts as upward, at top as downward
  assign dir_up_m = at_bot || (up_ff && !at_top);
  assign ovf_set  = (top_ev && single) || bot_ev;

  // counter steps on the enable only
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_up  = up_ff;
    if (tick && single) begin
      // clear on the enable after top
      // past a missed top, wraps at max
      nxt_cnt = at_top ? TPW_BOTTOM : cnt_ff + 16'h0001;
    end else if (tick && dual) begin
      if (up_ff && at_top) begin
        // top held one enable, then down
        nxt_up  = 1'b0;
        nxt_cnt = cnt_ff - 16'h0001;
      end else if (!up_ff && at_bot) begin
        nxt_up  = 1'b1;
        nxt_cnt = cnt_ff + 16'h0001;
      end else if (up_ff) begin
        // Top below the count: runs on through 0xffff
        nxt_cnt = cnt_ff + 16'h0001;
      end else begin
        nxt_cnt = cnt_ff - 16'h0001;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_ff <= TPW_VAL_RST;
      up_ff  <= 1'b1;
    end else begin
      cnt_ff <= nxt_cnt;
      up_ff  <= nxt_up;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_ff <= TPW_CTRL_RST;
      capt_ff <= TPW_VAL_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_ff <= hwdata[TPW_CTRL_WIDTH-1:0];
      end
      if (wr_capt) begin
        capt_ff <= hwdata[15:0];
      end
    end
  end

  // Per-channel compare, buffer and wave logic
  generate
    for (genvar i = 0; i < 2; i++) begin : g_ch
      logic nxt_wave;
      assign match[i] = tick && pwm && (cnt_ff == act_ff[i]);

      always_comb begin
        nxt_wave = wave_ff[i];
        if (match[i] && single && com[i] == TPW_COM_TOGGLE && i == 0) begin
          nxt_wave = !wave_ff[i];
        end else if (single && com[i][1]) begin
          if (top_ev) begin
            nxt_wave = com[i][0];
          end
          if (match[i]) begin
            nxt_wave = !com[i][0];
          end
        end else if (dual && com[i][1] && match[i]) begin
          nxt_wave = dir_up_m ? com[i][0] : !com[i][0];
        end
        // output mode zero leaves wave alone
      end

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          wave_ff[i] <= 1'b0;
          buf_ff[i]  <= TPW_VAL_RST;
          act_ff[i]  <= TPW_VAL_RST;
        end else begin
          wave_ff[i] <= nxt_wave;
          if (wr_cmp[i]) begin
            buf_ff[i] <= hwdata[15:0] & wr_mask;
          end
          // Outside PWM the active copies track the buffers
          if (!pwm) begin
            act_ff[i] <= buf_ff[i];
          end else if (top_ev) begin
            act_ff[i] <= buf_ff[i];
          end
        end
      end
    end
  endgenerate

  assign hit[0] = match[0] || (top_ev && top_cmpa);
  assign hit[1] = match[1];

  always_comb begin
    nxt_flags = flags_ff;
    // Clear first, sets after it: an event in the clear cycle wins
    if (wr_flags) begin
      nxt_flags = flags_ff & ~hwdata[3:0];
    end
    // overflow at top in fast mode
    // overflow at bottom in dual mode
    if (ovf_set) begin
      nxt_flags[TPW_FLG_OVF] = 1'b1;
    end
    if (hit[0]) begin
      nxt_flags[TPW_FLG_CMPA] = 1'b1;
    end
    if (hit[1]) begin
      nxt_flags[TPW_FLG_CMPB] = 1'b1;
    end
    if (top_ev && top_capt) begin
      nxt_flags[TPW_FLG_CAPT] = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_ff <= TPW_FLG_RST;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  assign pin_a_out = (com[0] != TPW_COM_OFF) ? wave_ff[0] : port_lvl[0];
  assign pin_b_out = (com[1] != TPW_COM_OFF) ? wave_ff[1] : port_lvl[1];
  assign pin_a_oe  = pin_dir[0];
  assign pin_b_oe  = pin_dir[1];

endmodule

// file: verif/tpw_pin_load.sv
// Pin load model for both timer pins.
// Assumes no pull on the pins, so a released pin shows a changing level.
`timescale 1ns/100ps
module tpw_pin_load (
  input  wire logic hclk,
  input  wire logic drv_a,
  input  wire logic oe_a,
  input  wire logic drv_b,
  input  wire logic oe_b,
  output logic      lvl_a,
  output logic      lvl_b
);
  logic last_a_ff = 1'b0;
  logic last_b_ff = 1'b0;
  always_ff @(posedge hclk) begin
    last_a_ff <= lvl_a;
    last_b_ff <= lvl_b;
  end
  assign lvl_a = oe_a ? drv_a : ~last_a_ff;
  assign lvl_b = oe_b ? drv_b : ~last_b_ff;
endmodule

// file: verif/tpw_timer16_pwm_chk.sv
// Checker for the PWM timer top: pins against control word, reset values.
// Assumes one AHB-Lite master; bound to every tpw_timer16_pwm.
`timescale 1ns/100ps
module tpw_timer16_pwm_chk
  import tpw_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        pin_a_out,
  input wire logic        pin_a_oe,
  input wire logic        pin_b_out,
  input wire logic        pin_b_oe
);
  logic        wr_ff;
  logic [14:0] sh_ff;
  wire         take_w  = hsel && hready && htrans[1];
  wire         stop_w  = (sh_ff[10:8] == 3'h0) || (sh_ff[10:8] > 3'h5);
  wire         fixed_w = !sh_ff[3] && (sh_ff[1:0] != 2'h0);
  wire         cnt_rd  = take_w && !hwrite && (haddr[7:0] == TPW_OFF_COUNT);
  wire  [15:0] top_w   = (sh_ff[1:0] == 2'h1) ? TPW_TOP8 :
                         (sh_ff[1:0] == 2'h2) ? TPW_TOP9 : TPW_TOP10;
  // Shadow of the control word
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ff <= 1'b0;
      sh_ff <= TPW_CTRL_RST;
    end else begin
      wr_ff <= take_w && hwrite && (haddr[7:0] == TPW_OFF_CTRL);
      if (wr_ff) sh_ff <= hwdata[14:0];
    end
  end
  default clocking dcb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_oe_a_dir: assert property (pin_a_oe == sh_ff[11])
    else $error("pin a enable differs from direction bit");
  chk_oe_b_dir: assert property (pin_b_oe == sh_ff[12])
    else $error("pin b enable differs from direction bit");
  chk_port_a_lvl: assert property (sh_ff[5:4] == 2'h0 |-> pin_a_out == sh_ff[13])
    else $error("pin a not at port level");
  chk_port_b_lvl: assert property (sh_ff[7:6] == 2'h0 |-> pin_b_out == sh_ff[14])
    else $error("pin b not at port level");
  chk_stop_hold: assert property (stop_w && $past(stop_w) && $past(stop_w, 2)
    && $stable(sh_ff) |-> $stable(pin_a_out) && $stable(pin_b_out))
    else $error("pin moved while timer stopped");
  chk_reset_pins: assert property ($rose(hresetn) |->
    !pin_a_out && !pin_b_out && !pin_a_oe && !pin_b_oe)
    else $error("pins not cleared by reset");
  chk_reset_rdata: assert property ($rose(hresetn) |-> hrdata == 32'h0)
    else $error("read data not cleared by reset");
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("slave not ready or response not okay");
  chk_count_top: assert property (cnt_rd && fixed_w |=> hrdata[15:0] <= top_w)
    else $error("count above fixed top");
  cover property ($rose(pin_a_out) && pin_a_oe);
  cover property (cnt_rd && fixed_w);
  cover property ($rose(pin_b_out) && sh_ff[7:6] == 2'h3);
endmodule
bind tpw_timer16_pwm tpw_timer16_pwm_chk tpw_timer16_pwm_chk_inst (.*);

// file: verif/tpw_timer16_pwm_tb.sv
// Bench for the PWM timer: every PWM mode, both polarities, prescaler.
// Assumes the bench is the only bus master; pins end in tpw_pin_load.
`timescale 1ns/100ps
module tpw_timer16_pwm_tb
  import tpw_pkg::*;
;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, q;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [3:0]  modes [10] = '{4'h5, 4'h6, 4'h7, 4'he, 4'hf, 4'h1, 4'h2, 4'h3, 4'ha, 4'hb};
  logic [31:0] hrdata;
  logic        hreadyout, hresp, pin_a_out, pin_a_oe, pin_b_out, pin_b_oe, lvl_a, lvl_b;
  int          err_total = 0, n_tests = 0, seed = 30864, t, ca, cb, fx, dl;
  always #4 hclk = ~hclk;
  tpw_timer16_pwm tpw_timer16_pwm_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .pin_a_out(pin_a_out), .pin_a_oe(pin_a_oe), .pin_b_out(pin_b_out), .pin_b_oe(pin_b_oe));
  tpw_pin_load tpw_pin_load_inst (.hclk(hclk), .drv_a(pin_a_out), .oe_a(pin_a_oe),
    .drv_b(pin_b_out), .oe_b(pin_b_oe), .lvl_a(lvl_a), .lvl_b(lvl_b));
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim;
    $display("tests %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
    @(posedge hclk);
  endtask
  function automatic int rnd(int n);
    return ($random(seed) & 32'hffff) % n;
  endfunction
  function automatic logic [31:0] ctl(int m, int ca, int cb, int cs, int dir, int port);
    return m | (ca << TPW_CTRL_COMA_LSB) | (cb << TPW_CTRL_COMB_LSB) |
      (cs << TPW_CTRL_CS_LSB) | (dir << TPW_CTRL_DIR_LSB) | (port << TPW_CTRL_PORT_LSB);
  endfunction
  // High cycles over two periods
  function automatic int hi_exp(int dual, int com, int t, int c);
    if (com == 1) return t + 1;
    if (dual) return 4 * ((com == 3) ? (t - c) : c);
    if (c == t) return (com == 3) ? 0 : 2 * (t + 1);
    return 2 * ((com == 3) ? (c + 1) : (t - c));
  endfunction
  task automatic run(input int m, t, ca, cb, coma, comb, cs, nd);
    int dual, p, ha, hb;
    logic [15:0] r;
    dual = (m < 4) || (m == 10) || (m == 11);
    p = nd * (dual ? 2 * t : t + 1);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(TPW_OFF_CTRL, 1'b1, ctl(m, 0, 0, 0, 0, 0));
    r = 16'($random(seed));
    bus(TPW_OFF_CMPB, 1'b1, {16'h0, r});
    bus(TPW_OFF_CMPB, 1'b0, 32'h0);
    check("cmpb mask", q, {16'h0, fx ? (r & 16'(t)) : r});
    // Mode 0 lets the active compares follow the buffers before start
    bus(TPW_OFF_CTRL, 1'b1, ctl(0, 0, 0, 0, 0, 0));
    bus(TPW_OFF_CAPT, 1'b1, 32'(t));
    bus(TPW_OFF_CMPA, 1'b1, 32'(ca));
    bus(TPW_OFF_CMPB, 1'b1, 32'(cb));
    bus(TPW_OFF_CTRL, 1'b1, ctl(m, coma, comb, cs, 3, 0));
    repeat (2 * p) @(posedge hclk);
    bus(TPW_OFF_COUNT, 1'b0, 32'h0);
    check("count", 32'(q <= t), 32'h1);
    ha = 0;
    hb = 0;
    repeat (2 * p) begin
      @(posedge hclk);
      ha += (lvl_a === 1'b1);
      hb += (lvl_b === 1'b1);
    end
    check("high a", ha, nd * hi_exp(dual, coma, t, ca));
    check("high b", hb, nd * hi_exp(dual, comb, t, cb));
    bus(TPW_OFF_CTRL, 1'b1, ctl(m, coma, comb, 0, 3, 0));
    bus(TPW_OFF_FLAGS, 1'b0, 32'h0);
    check("flags", q, {28'h0, m == 14 || m == 10, 3'h7});
    bus(TPW_OFF_FLAGS, 1'b1, 32'hf);
    bus(TPW_OFF_FLAGS, 1'b0, 32'h0);
    check("flags clear", q, 32'h0);
  endtask
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int a = 0; a <= 24; a += 4) begin
      bus(8'(a), 1'b0, 32'h0);
      check("reset value", q, 32'h0);
    end
    foreach (modes[i]) begin
      fx = (modes[i][1:0] != 2'h0) && !modes[i][3];
      dl = (modes[i] < 4) || (modes[i] == 10) || (modes[i] == 11);
      // top at least three, compares within top, top fixed per run
      t = !fx ? 3 + rnd(32) : (modes[i][1:0] == 2'h1) ? 255 : (modes[i][1:0] == 2'h2) ? 511 : 1023;
      ca = (modes[i][1:0] == 2'h3 && modes[i][3]) ? t : rnd(t + 1);
      cb = (modes[i] == 14 || modes[i] == 10) ? 0 : rnd(t + 1);
      run(modes[i], t, ca, cb, dl ? 2 + rnd(2) : 1 + rnd(3), 2 + rnd(2), 1, 1);
    end
    fx = 0;
    for (int s = 1; s <= 5; s++) begin
      run(14, 3, 1, 3, 2, 3, s, (s == 1) ? 1 : (s == 2) ? 8 : (s == 3) ? 64 : (s == 4) ? 256 : 1024);
    end
    bus(TPW_OFF_CTRL, 1'b1, ctl(14, 2, 3, 6, 3, 0));
    bus(TPW_OFF_COUNT, 1'b0, 32'h0);
    t = q;
    repeat (50) @(posedge hclk);
    bus(TPW_OFF_COUNT, 1'b0, 32'h0);
    check("stop select", q, 32'(t));
    bus(TPW_OFF_CTRL, 1'b1, ctl(0, 0, 0, 0, 3, 3));
    check("port level", {lvl_a, lvl_b}, 2'h3);
    bus(TPW_OFF_CTRL, 1'b1, ctl(0, 0, 0, 0, 0, 3));
    check("pin enable", {pin_a_oe, pin_b_oe}, 2'h0);
    end_sim;
  end
  initial begin
    #600000;
    err_total++;
    end_sim;
  end
endmodule
